// ### rtl/tcct_timer.sv
// Two-channel capture/compare timer with APB register slave
//
// Functional notes
// - Overflow flag sets at modulo match
// - Overflow flag cleared by read then 0-write
// - Overflow irq when flag and enable
// - Halt bit resets to 1
// - Halt blocks input captures
// - Counter reset bit clears counter, prescaler
// - Divider select picks 1..64, 111 unused
// - High count read latches low byte
// - Counter wraps after modulo, period mod+1
// - Modulo high write blocks overflow flag until low
// - Modulo resets to all ones
// - Channel flag on capture edge or compare
// - Channel flag cleared by read then 0-write
// - Channel irq when flag and enable
// - Buffered select on channel 0 links pair
// - Mode bit A: compare/capture or level
// - Edge/level field picks edge or action
// - Toggle on overflow, overflow wins
// - Full duty force from next period
// - High value read blocks capture until low
// - High value write blocks compare until low
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module tcct_timer
  import tcct_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel pins
  input wire logic [1:0] chan_pin_in,
  output logic [1:0] chan_pin_out,
  output logic [1:0] chan_pin_oe,
  // Interrupt requests
  output logic overflow_irq,
  output logic [1:0] channel_irq
);
  logic overflow_flag_reg, overflow_irq_enable_reg, counter_halt_reg;
  logic [2:0] divider_select_reg;
  logic [15:0] count_reg, period_limit_reg, mod_pend_reg;
  logic mod_lock_reg, ovf_armed_reg;
  logic [7:0] cnt_low_latch_reg;
  logic cnt_latched_reg;
  logic [6:0] presc_reg;
  tcct_csc_t csc_reg [2];
  logic [15:0] chan_value_reg [2];
  logic [1:0] cap_lock_reg, cmp_lock_reg, chan_armed_reg;
  logic [1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [1:0] pin_level_reg;
  logic [1:0] max_active_reg;
  logic active_ch1_reg, pending_ch1_reg;

  logic wr_en, rd_en, tick, ovf_event, count_zero_reset;
  logic [31:0] rd_data;
  logic [1:0] cap_event, cmp_event, chan_event, ch_enabled;
  logic [15:0] cmp_value;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign count_zero_reset = wr_en && paddr == ADDR_TSC && pwdata[TSC_CRST];

  always_comb begin
    case (divider_select_reg)
      3'h0: tick = 1'b1;
      3'h1: tick = presc_reg[0];
      3'h2: tick = &presc_reg[1:0];
      3'h3: tick = &presc_reg[2:0];
      3'h4: tick = &presc_reg[3:0];
      3'h5: tick = &presc_reg[4:0];
      3'h6: tick = &presc_reg[5:0];
      default: tick = 1'b0;
    endcase
  end

  // overflow when counter sits at modulo on a tick
  assign ovf_event = tick && !counter_halt_reg && count_reg == period_limit_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 7'h00;
    end else if (count_zero_reset) begin
      presc_reg <= 7'h00;
    end else if (!counter_halt_reg) begin
      presc_reg <= presc_reg + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= CNT_RESET;
    end else if (count_zero_reset) begin
      count_reg <= CNT_RESET;
    end else if (ovf_event) begin
      count_reg <= CNT_RESET;
    end else if (tick && !counter_halt_reg) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // modulo reset; high write locks the overflow flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_limit_reg <= MOD_RESET;
      mod_pend_reg <= MOD_RESET;
      mod_lock_reg <= 1'b0;
    end else if (wr_en && paddr == ADDR_MODH) begin
      mod_pend_reg[15:8] <= pwdata[7:0];
      mod_lock_reg <= 1'b1;
    end else if (wr_en && paddr == ADDR_MODL) begin
      period_limit_reg <= {mod_pend_reg[15:8], pwdata[7:0]};
      mod_pend_reg[7:0] <= pwdata[7:0];
      mod_lock_reg <= 1'b0;
    end
  end

  // overflow flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_reg <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else begin
      if (ovf_event && !mod_lock_reg) begin
        overflow_flag_reg <= 1'b1;
        ovf_armed_reg <= 1'b0;
      end else if (wr_en && paddr == ADDR_TSC) begin
        if (ovf_armed_reg && !pwdata[TSC_OVF]) begin
          overflow_flag_reg <= 1'b0;
        end
        ovf_armed_reg <= 1'b0;
      end else if (rd_en && paddr == ADDR_TSC && overflow_flag_reg) begin
        ovf_armed_reg <= 1'b1;
      end
    end
  end

  // halt out of reset; divider reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_reg <= 1'b0;
      counter_halt_reg <= 1'b1;
      divider_select_reg <= DIV_RESET;
    end else if (wr_en && paddr == ADDR_TSC) begin
      overflow_irq_enable_reg <= pwdata[TSC_OIE];
      counter_halt_reg <= pwdata[TSC_HALT];
      divider_select_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_low_latch_reg <= 8'h00;
      cnt_latched_reg <= 1'b0;
    end else if (rd_en && paddr == ADDR_CNTH && !cnt_latched_reg) begin
      cnt_low_latch_reg <= count_reg[7:0];
      cnt_latched_reg <= 1'b1;
    end else if (rd_en && paddr == ADDR_CNTL) begin
      cnt_latched_reg <= 1'b0;
    end
  end

  // Pin synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 2'b00;
      pin_s2_reg <= 2'b00;
      pin_s3_reg <= 2'b00;
    end else begin
      pin_s1_reg <= chan_pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // channel 1 idle while pair is linked
  assign ch_enabled[0] = 1'b1;
  assign ch_enabled[1] = !csc_reg[0].msb;
  // linked pair compares against the active register set
  assign cmp_value = (csc_reg[0].msb && active_ch1_reg) ? chan_value_reg[1] : chan_value_reg[0];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic is_cap, is_cmp, rise, fall;
      assign is_cap = ch_enabled[gi] && !csc_reg[gi].msb && !csc_reg[gi].msa &&
                      (csc_reg[gi].elb || csc_reg[gi].ela);
      assign is_cmp = ch_enabled[gi] && (csc_reg[gi].msa || csc_reg[gi].msb);
      assign rise = pin_s2_reg[gi] && !pin_s3_reg[gi];
      assign fall = !pin_s2_reg[gi] && pin_s3_reg[gi];
      // capture gated by halt and read lock
      assign cap_event[gi] = is_cap && !counter_halt_reg && !cap_lock_reg[gi] &&
                             ((csc_reg[gi].ela && rise) || (csc_reg[gi].elb && fall));
      assign cmp_event[gi] = is_cmp && !cmp_lock_reg[gi] && tick && !counter_halt_reg &&
                             count_reg == (gi == 0 ? cmp_value : chan_value_reg[gi]);
      assign chan_event[gi] = cap_event[gi] || cmp_event[gi];
    end
  endgenerate

  // Channel value registers, captures and lock bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_value_reg[0] <= CNT_RESET;
      chan_value_reg[1] <= CNT_RESET;
      cap_lock_reg <= 2'b00;
      cmp_lock_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_event[i]) begin
          chan_value_reg[i] <= count_reg;
        end else if (wr_en && paddr == (i == 0 ? ADDR_CVH0 : ADDR_CVH1)) begin
          chan_value_reg[i][15:8] <= pwdata[7:0];
        end else if (wr_en && paddr == (i == 0 ? ADDR_CVL0 : ADDR_CVL1)) begin
          chan_value_reg[i][7:0] <= pwdata[7:0];
        end
        if (rd_en && paddr == (i == 0 ? ADDR_CVH0 : ADDR_CVH1) &&
            !csc_reg[i].msb && !csc_reg[i].msa) begin
          cap_lock_reg[i] <= 1'b1;
        end else if (rd_en && paddr == (i == 0 ? ADDR_CVL0 : ADDR_CVL1)) begin
          cap_lock_reg[i] <= 1'b0;
        end
        if (wr_en && paddr == (i == 0 ? ADDR_CVH0 : ADDR_CVH1) &&
            (csc_reg[i].msb || csc_reg[i].msa)) begin
          cmp_lock_reg[i] <= 1'b1;
        end else if (wr_en && paddr == (i == 0 ? ADDR_CVL0 : ADDR_CVL1)) begin
          cmp_lock_reg[i] <= 1'b0;
        end
      end
    end
  end

  // buffered pair tracks last-written set, swaps on overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ch1_reg <= 1'b0;
      pending_ch1_reg <= 1'b0;
    end else begin
      if (wr_en && (paddr == ADDR_CVL1 || paddr == ADDR_CVH1)) begin
        pending_ch1_reg <= 1'b1;
      end else if (wr_en && (paddr == ADDR_CVL0 || paddr == ADDR_CVH0)) begin
        pending_ch1_reg <= 1'b0;
      end
      if (!csc_reg[0].msb) begin
        active_ch1_reg <= 1'b0;
      end else if (ovf_event) begin
        active_ch1_reg <= pending_ch1_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csc_reg[0] <= '0;
      csc_reg[1] <= '0;
      chan_armed_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_en && paddr == (i == 0 ? ADDR_CSC0 : ADDR_CSC1) && ch_enabled[i]) begin
          csc_reg[i].ie <= pwdata[CSC_IE];
          csc_reg[i].msb <= (i == 0) ? pwdata[CSC_MSB] : 1'b0;
          csc_reg[i].msa <= pwdata[CSC_MSA];
          csc_reg[i].elb <= pwdata[CSC_ELB];
          csc_reg[i].ela <= pwdata[CSC_ELA];
          csc_reg[i].tov <= pwdata[CSC_TOV];
          csc_reg[i].max <= pwdata[CSC_MAX];
        end
        if (chan_event[i]) begin
          csc_reg[i].flag <= 1'b1;
          chan_armed_reg[i] <= 1'b0;
        end else if (wr_en && paddr == (i == 0 ? ADDR_CSC0 : ADDR_CSC1)) begin
          if (chan_armed_reg[i] && !pwdata[CSC_FLAG]) begin
            csc_reg[i].flag <= 1'b0;
          end
          chan_armed_reg[i] <= 1'b0;
        end else if (rd_en && paddr == (i == 0 ? ADDR_CSC0 : ADDR_CSC1) && csc_reg[i].flag) begin
          chan_armed_reg[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_reg <= 2'b11;
      max_active_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!csc_reg[i].elb && !csc_reg[i].ela) begin
          pin_level_reg[i] <= !csc_reg[i].msa;
        end else if (ovf_event && csc_reg[i].tov && (csc_reg[i].msa || csc_reg[i].msb)) begin
          max_active_reg[i] <= csc_reg[i].max;
          if (csc_reg[i].max && csc_reg[i].elb && !csc_reg[i].ela) begin
            pin_level_reg[i] <= 1'b1;
          end else begin
            pin_level_reg[i] <= !pin_level_reg[i];
          end
        end else if (cmp_event[i] && !max_active_reg[i]) begin
          case ({csc_reg[i].elb, csc_reg[i].ela})
            2'b01: pin_level_reg[i] <= !pin_level_reg[i];
            2'b10: pin_level_reg[i] <= 1'b0;
            2'b11: pin_level_reg[i] <= 1'b1;
            default: pin_level_reg[i] <= pin_level_reg[i];
          endcase
        end
      end
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      ADDR_TSC: rd_data[7:0] = {overflow_flag_reg, overflow_irq_enable_reg,
                                counter_halt_reg, 1'b0, 1'b0, divider_select_reg};
      ADDR_CNTH: rd_data[7:0] = count_reg[15:8];
      ADDR_CNTL: rd_data[7:0] = cnt_latched_reg ? cnt_low_latch_reg : count_reg[7:0];
      ADDR_MODH: rd_data[7:0] = period_limit_reg[15:8];
      ADDR_MODL: rd_data[7:0] = period_limit_reg[7:0];
      ADDR_CSC0: rd_data[7:0] = csc_reg[0];
      ADDR_CVH0: rd_data[7:0] = chan_value_reg[0][15:8];
      ADDR_CVL0: rd_data[7:0] = chan_value_reg[0][7:0];
      ADDR_CSC1: rd_data[7:0] = csc_reg[1];
      ADDR_CVH1: rd_data[7:0] = chan_value_reg[1][15:8];
      ADDR_CVL1: rd_data[7:0] = chan_value_reg[1][7:0];
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Registered outputs; zero-wait APB
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= 1'b0;
      overflow_irq <= 1'b0;
      channel_irq <= 2'b00;
      chan_pin_out <= 2'b00;
      chan_pin_oe <= 2'b00;
    end else begin
      prdata <= (psel && !penable && !pwrite) ? rd_data : prdata;
      pready <= 1'b1;
      pslverr <= 1'b0;
      overflow_irq <= overflow_flag_reg && overflow_irq_enable_reg;
      channel_irq[0] <= csc_reg[0].flag && csc_reg[0].ie;
      channel_irq[1] <= csc_reg[1].flag && csc_reg[1].ie && ch_enabled[1];
      chan_pin_out <= pin_level_reg;
      for (int i = 0; i < 2; i++) begin
        chan_pin_oe[i] <= ch_enabled[i] && (csc_reg[i].msa || csc_reg[i].msb) &&
                          (csc_reg[i].elb || csc_reg[i].ela);
      end
    end
  end
endmodule

// ### rtl/tcct_pkg.sv
// Package: register map, field positions and types for the capture/compare timer
package tcct_pkg;
  localparam logic [7:0] ADDR_TSC = 8'h00;
  localparam logic [7:0] ADDR_CNTH = 8'h04;
  localparam logic [7:0] ADDR_CNTL = 8'h08;
  localparam logic [7:0] ADDR_MODH = 8'h0C;
  localparam logic [7:0] ADDR_MODL = 8'h10;
  localparam logic [7:0] ADDR_CSC0 = 8'h14;
  localparam logic [7:0] ADDR_CVH0 = 8'h18;
  localparam logic [7:0] ADDR_CVL0 = 8'h1C;
  localparam logic [7:0] ADDR_CSC1 = 8'h20;
  localparam logic [7:0] ADDR_CVH1 = 8'h24;
  localparam logic [7:0] ADDR_CVL1 = 8'h28;
  // Timer status/control fields
  localparam int TSC_OVF = 7;
  localparam int TSC_OIE = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_CRST = 4;
  // Channel status/control fields
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE = 6;
  localparam int CSC_MSB = 5;
  localparam int CSC_MSA = 4;
  localparam int CSC_ELB = 3;
  localparam int CSC_ELA = 2;
  localparam int CSC_TOV = 1;
  localparam int CSC_MAX = 0;
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] DIV_UNUSED = 3'h7;
  localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;
  typedef struct packed {
    logic flag;
    logic ie;
    logic msb;
    logic msa;
    logic elb;
    logic ela;
    logic tov;
    logic max;
  } tcct_csc_t;
endpackage

// ### test/tcct_monitor.sv
// Port-level checker for the capture/compare timer
`timescale 1ns/1ps
module tcct_monitor
  import tcct_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Pins and requests
  input wire logic [1:0] chan_pin_oe,
  input wire logic overflow_irq,
  input wire logic [1:0] channel_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cfg_reg;
  logic [7:0] cfg_d_reg;
  logic oie_reg;
  logic oie_d_reg;
  logic park_reg;
  logic mdef_reg;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  wire drv = (cfg_reg[5] || cfg_reg[4]) && cfg_reg[3:2] != 2'b00;
  wire drv_d = (cfg_d_reg[5] || cfg_d_reg[4]) && cfg_d_reg[3:2] != 2'b00;
  // Shadow of written control fields, plus one-cycle delayed copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= 8'h00;
      cfg_d_reg <= 8'h00;
      oie_reg <= 1'b0;
      oie_d_reg <= 1'b0;
      park_reg <= 1'b1;
      mdef_reg <= 1'b1;
    end else begin
      cfg_d_reg <= cfg_reg;
      oie_d_reg <= oie_reg;
      if (wr && paddr == ADDR_CSC0) begin
        cfg_reg <= pwdata[7:0];
      end
      if (wr && paddr == ADDR_TSC) begin
        oie_reg <= pwdata[TSC_OIE];
        park_reg <= pwdata[TSC_HALT] && (pwdata[TSC_CRST] || park_reg);
      end
      if (wr && (paddr == ADDR_MODH || paddr == ADDR_MODL)) begin
        mdef_reg <= 1'b0;
      end
    end
  end
  property p_oirq;
    !oie_reg && !oie_d_reg |-> !overflow_irq;
  endproperty
  a_oirq: assert property (p_oirq) else $error("overflow irq while disabled");
  property p_cirq;
    !cfg_reg[6] && !cfg_d_reg[6] |-> !channel_irq[0];
  endproperty
  a_cirq: assert property (p_cirq) else $error("channel irq while disabled");
  property p_link;
    cfg_reg[5] && cfg_d_reg[5] |-> !channel_irq[1] && !chan_pin_oe[1];
  endproperty
  a_link: assert property (p_link) else $error("channel 1 active while linked");
  property p_cap;
    !drv && !drv_d |-> !chan_pin_oe[0];
  endproperty
  a_cap: assert property (p_cap) else $error("pin driven in capture or port mode");
  property p_drv;
    drv && drv_d |-> chan_pin_oe[0];
  endproperty
  a_drv: assert property (p_drv) else $error("compare pin not driven");
  property p_trst;
    rd && paddr == ADDR_TSC |-> !prdata[TSC_CRST];
  endproperty
  a_trst: assert property (p_trst) else $error("counter reset bit reads 1");
  property p_mod;
    rd && mdef_reg && (paddr == ADDR_MODH || paddr == ADDR_MODL) |-> prdata == 32'h0000_00FF;
  endproperty
  a_mod: assert property (p_mod) else $error("modulo not all ones");
  property p_park;
    rd && park_reg && paddr == ADDR_CNTH |-> prdata == 32'h0000_0000;
  endproperty
  a_park: assert property (p_park) else $error("parked counter not zero");
  c_oirq: cover property ($rose(overflow_irq));
  c_cirq: cover property ($rose(channel_irq[1]));
  c_link: cover property (cfg_reg[5] && chan_pin_oe[0]);
endmodule

// ### test/tcct_pin_model.sv
// External pin model: resolves each channel wire from both drivers
`timescale 1ns/1ps
module tcct_pin_model (
  // Design side
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // Outside driver
  input wire logic [1:0] ext_level,
  output logic [1:0] pin_wire
);
  assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### test/tb_top.sv
// Self-checking testbench for the capture/compare timer
`timescale 1ns/1ps
module tb_top;
  import tcct_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, overflow_irq;
  logic [7:0] paddr, m, c;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] pin_in, pin_out, pin_oe, channel_irq, lvl;
  logic [15:0] seed;
  int num_errors, checked, cyc, n;
  tcct_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
    .chan_pin_oe(pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
  tcct_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(lvl),
    .pin_wire(pin_in));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) num_errors++;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(q, {24'h0, e});
    chk(32'(pslverr), 32'h0);
  endtask
  task automatic gap(output int g);
    logic o;
    o = pin_out[0];
    g = 0;
    while (pin_out[0] === o && g < 2000) begin
      @(posedge pclk);
      g++;
    end
  endtask
  task automatic cap(input logic v, input logic [7:0] cv, input logic f);
    @(posedge pclk);
    lvl[1] <= v;
    repeat (8) @(posedge pclk);
    rd(ADDR_CSC1, {f, cv[6:0]});
    chk(32'(channel_irq[1]), 32'(f));
    wr(ADDR_CSC1, cv);
  endtask
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, lvl} = '0;
    {num_errors, checked, cyc} = '0;
    seed = 16'h2453;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_TSC, 8'h20);
    rd(ADDR_MODH, 8'hFF);
    rd(ADDR_MODL, 8'hFF);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_CSC0, 8'h00);
    rd(8'h2C, 8'h00);
    // Overflow toggle period for every divider code
    for (int d = 0; d < 8; d++) begin
      seed = lfsr(seed);
      m = {5'h0, seed[2:0]} + 8'h02;
      wr(ADDR_TSC, 8'h30);
      wr(ADDR_MODH, 8'h00);
      wr(ADDR_MODL, m);
      wr(ADDR_CVH0, 8'hFF);
      wr(ADDR_CVL0, 8'hFF);
      wr(ADDR_CSC0, 8'h1A);
      wr(ADDR_TSC, 8'(d));
      gap(n);
      gap(n);
      chk(32'(n), d == 7 ? 32'd2000 : 32'((m + 1) << d));
    end
    // Flag clear needs a prior read
    wr(ADDR_TSC, 8'h30);
    wr(ADDR_TSC, 8'h40);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(overflow_irq), 32'h1);
    wr(ADDR_TSC, 8'h60);
    rd(ADDR_TSC, 8'hE0);
    wr(ADDR_TSC, 8'h60);
    rd(ADDR_TSC, 8'h60);
    chk(32'(overflow_irq), 32'h0);
    wr(ADDR_TSC, 8'hE0);
    rd(ADDR_TSC, 8'h60);
    // Capture edges, halted then running
    for (int e = 1; e < 4; e++) begin
      c = 8'h40 | 8'(e << 2);
      wr(ADDR_TSC, 8'h30);
      wr(ADDR_CSC1, c | 8'h80);
      cap(1'b1, c, 1'b0);
      cap(1'b0, c, 1'b0);
      wr(ADDR_TSC, 8'h00);
      cap(1'b1, c, e[0]);
      cap(1'b0, c, e[1]);
    end
    // Linked pair
    wr(ADDR_TSC, 8'h30);
    wr(ADDR_CSC0, 8'h28);
    wr(ADDR_CSC1, 8'h50);
    rd(ADDR_CSC1, 8'h4C);
    chk(32'(pin_oe), 32'h1);
    // Overflow seen while capturing, then cleared
    rd(ADDR_TSC, 8'hA0);
    wr(ADDR_TSC, 8'h30);
    // Modulo high write holds the flag off
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_TSC, 8'h00);
    repeat (30) @(posedge pclk);
    wr(ADDR_TSC, 8'h30);
    rd(ADDR_TSC, 8'h20);
    wr(ADDR_MODL, 8'hFF);
    // Low count byte latched by high read
    rd(ADDR_CNTH, 8'h00);
    wr(ADDR_TSC, 8'h00);
    wr(ADDR_TSC, 8'h20);
    rd(ADDR_CNTH, 8'h00);
    rd(ADDR_CNTL, 8'h00);
    rd(ADDR_CNTL, 8'h03);
    // Software compare on channel 0, high write locks it
    wr(ADDR_TSC, 8'h30);
    wr(ADDR_CSC0, 8'h50);
    wr(ADDR_CVL0, 8'h05);
    wr(ADDR_CVH0, 8'h00);
    wr(ADDR_TSC, 8'h00);
    repeat (300) @(posedge pclk);
    rd(ADDR_CSC0, 8'h50);
    wr(ADDR_CVL0, 8'h05);
    repeat (300) @(posedge pclk);
    wr(ADDR_TSC, 8'h30);
    rd(ADDR_CSC0, 8'hD0);
    chk(32'(channel_irq[0]), 32'h1);
    // Capture held off by a high value read
    wr(ADDR_TSC, 8'h00);
    apb(1'b0, ADDR_CVH1, 8'h00, q);
    cap(1'b1, 8'h4C, 1'b0);
    apb(1'b0, ADDR_CVL1, 8'h00, q);
    cap(1'b0, 8'h4C, 1'b1);
    tally_and_finish;
  end
endmodule
bind tcct_timer tcct_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .chan_pin_oe(chan_pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
